// >>> rtl/bhb_engine.sv
// bayer histogram binning engine with apb registers and counter memory
`timescale 1ns/100ps
// Functional notes
// - control source field picks video port or memory read buffer pixels
// - video port pixels are taken as 10-bit values
// - memory pixels have a programmable width from 8 to 14 bits
// - packed mode splits each 16-bit word into two 8-bit pixels
// - frame width and line count come from frame size register
// - colour index is 0,1 on even lines and 2,3 on odd lines
// - each pixel is multiplied by an unsigned U8Q5 colour gain
// - gain fields a to d map to tile positions 0 to 3
// - bins per colour selectable as 32, 64, 128 or 256
// - four regions with inclusive start and end pixel and line
// - region with equal start and end coordinates counts nothing
// - a pixel counts only in the lowest-numbered containing region
// - pixel is right-shifted by the programmed shift before binning
// - shifted values above the top bin go into the top bin
// - counters are 20 bits and saturate at all ones
// - address is region base plus colour times bins plus bin
// - memory reached by pointer and port; each port access increments
// - clear-on-read zeroes a word right after it is read
module bhb_engine
    import bhb_pkg::*;
(
    input wire logic clk,                 // system clock
    input wire logic reset,               // synchronous reset
    input wire logic psel,                // apb select
    input wire logic penable,             // apb enable
    input wire logic pwrite,              // apb direction
    input wire logic [7:0] paddr,         // apb byte address
    input wire logic [31:0] pwdata,       // apb write data
    output logic [31:0] prdata,           // apb read data
    output logic pready,                  // apb ready
    output logic pslverr,                 // apb error
    input wire logic vp_valid,            // video port pixel valid
    input wire logic [9:0] vp_data,       // video port pixel
    input wire logic rb_valid,            // read buffer word valid
    input wire logic [15:0] rb_data,      // read buffer word
    output logic rb_ready,                // read buffer word accepted
    output logic [31:0] rd_start,         // memory_read_start to reader
    output logic [31:0] rd_stride,        // memory_line_stride to reader
    output logic frame_busy               // binning in progress
);
    // ==========================================
    // registers
    logic [31:0] ctl_q, gain_q, frame_q, rdstart_q, stride_q;
    logic [31:0] cols_q [4], rows_q [4];
    logic [BHB_AW-1:0] ptr_q;
    logic [BHB_CNT_WIDTH-1:0] mem [BHB_MEM_WORDS];
    bhb_state_e state_q;
    logic [BHB_COORD_W-1:0] col_q, line_q;
    logic hi_half_q;
    logic [31:0] rdata_d, prdata_q;
    logic access, wr, rd, is_port, err;

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign is_port = paddr == BHB_OFF_PORT;
    assign pready = 1'b1;
    assign pslverr = access && err;
    assign rd_start = rdstart_q;
    assign rd_stride = stride_q;
    assign frame_busy = state_q == BHB_RUN;

    wire src_mem = ctl_q[BHB_CTL_SOURCE];
    wire packed_px = ctl_q[BHB_CTL_PACKED];
    wire [1:0] bins_sel = ctl_q[BHB_CTL_BINS_LO +: 2];
    wire [3:0] shift_amt = ctl_q[BHB_CTL_SHIFT_LO +: 4];
    wire [3:0] reg_en = ctl_q[BHB_CTL_REGEN_LO +: 4];
    wire [3:0] mem_w = ctl_q[BHB_CTL_WIDTH_LO +: 4];
    wire [BHB_COORD_W-1:0] f_width = frame_q[BHB_COORD_W-1:0];
    wire [BHB_COORD_W-1:0] f_lines = frame_q[16 +: BHB_COORD_W];

    // ==========================================
    // apb register writes
    // start and stride keep their low five bits at zero for the reader
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_q <= BHB_CTL_RESET;
            gain_q <= BHB_GAIN_RESET;
            frame_q <= '0;
            rdstart_q <= '0;
            stride_q <= '0;
            for (int i = 0; i < 4; i++) begin
                cols_q[i] <= '0;
                rows_q[i] <= '0;
            end
        end else if (wr) begin
            case (paddr)
                BHB_OFF_CONTROL: ctl_q <= pwdata;
                BHB_OFF_FRAME: frame_q <= pwdata;
                BHB_OFF_GAIN: gain_q <= pwdata;
                BHB_OFF_RDSTART: rdstart_q <= {pwdata[31:5], 5'h00};
                BHB_OFF_STRIDE: stride_q <= {pwdata[31:5], 5'h00};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (paddr == BHB_OFF_COLS0 + 8'(8 * i))
                            cols_q[i] <= pwdata;
                        if (paddr == BHB_OFF_ROWS0 + 8'(8 * i))
                            rows_q[i] <= pwdata;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // apb read mux
    always_comb begin
        rdata_d = '0;
        err = 1'b0;
        case (paddr)
            BHB_OFF_CONTROL: rdata_d = ctl_q;
            BHB_OFF_FRAME: rdata_d = frame_q;
            BHB_OFF_GAIN: rdata_d = gain_q;
            BHB_OFF_PTR: rdata_d = {22'h000000, ptr_q};
            BHB_OFF_PORT: rdata_d = {12'h000, mem[ptr_q]};
            BHB_OFF_STATUS: rdata_d = {30'h00000000, state_q};
            BHB_OFF_RDSTART: rdata_d = rdstart_q;
            BHB_OFF_STRIDE: rdata_d = stride_q;
            default: begin
                err = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    if (paddr == BHB_OFF_COLS0 + 8'(8 * i)) begin
                        rdata_d = cols_q[i];
                        err = 1'b0;
                    end
                    if (paddr == BHB_OFF_ROWS0 + 8'(8 * i)) begin
                        rdata_d = rows_q[i];
                        err = 1'b0;
                    end
                end
            end
        endcase
    end
    // read data is caught at the end of the setup cycle, so the word
    // stands in a flip-flop for the whole access phase; a pixel that hits
    // the pointed counter in that one cycle is not seen by the read
    always_ff @(posedge clk) begin
        if (reset)
            prdata_q <= '0;
        else if (psel && !penable && !pwrite)
            prdata_q <= rdata_d;
    end
    assign prdata = prdata_q;

    // ==========================================
    // pixel source selection and unpacking
    // a width field outside the supported range is clamped, so a bad value
    // never masks the whole pixel away
    logic [3:0] mem_w_eff;
    always_comb begin
        mem_w_eff = mem_w;
        if (mem_w < 4'(BHB_MEM_MIN_WIDTH))
            mem_w_eff = 4'(BHB_MEM_MIN_WIDTH);
        else if (mem_w > 4'(BHB_MEM_MAX_WIDTH))
            mem_w_eff = 4'(BHB_MEM_MAX_WIDTH);
    end

    logic px_valid;
    logic [13:0] px_raw;
    always_comb begin
        px_valid = 1'b0;
        px_raw = '0;
        rb_ready = 1'b0;
        if (state_q == BHB_RUN) begin
            if (!src_mem) begin
                px_valid = vp_valid;
                px_raw = {4'h0, vp_data};
            end else begin
                px_valid = rb_valid;
                if (packed_px) begin
                    px_raw = hi_half_q ? {6'h00, rb_data[15:8]}
                                       : {6'h00, rb_data[7:0]};
                    rb_ready = rb_valid && hi_half_q;
                end else begin
                    px_raw = rb_data[13:0] &
                             ~(14'h3fff << mem_w_eff);
                    rb_ready = rb_valid;
                end
            end
        end
    end

    // low byte of a packed word goes first; the word is taken with the high
    // byte, so the reader sees one handshake per two pixels
    always_ff @(posedge clk) begin
        if (reset || state_q != BHB_RUN || !src_mem || !packed_px)
            hi_half_q <= 1'b0;
        else if (px_valid)
            hi_half_q <= !hi_half_q;
    end

    // ==========================================
    // frame sequencing
    // clearing enable mid-frame returns to idle; counts already made stay
    wire last_col = col_q == f_width - 14'h0001;
    wire last_line = line_q == f_lines - 14'h0001;
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= BHB_IDLE;
            col_q <= '0;
            line_q <= '0;
        end else begin
            case (state_q)
                BHB_IDLE: begin
                    col_q <= '0;
                    line_q <= '0;
                    if (ctl_q[BHB_CTL_ENABLE] && f_width != '0 &&
                        f_lines != '0)
                        state_q <= BHB_RUN;
                end
                BHB_RUN: begin
                    if (!ctl_q[BHB_CTL_ENABLE])
                        state_q <= BHB_IDLE;
                    else if (px_valid) begin
                        if (last_col) begin
                            col_q <= '0;
                            line_q <= line_q + 14'h0001;
                            if (last_line)
                                state_q <= BHB_DONE;
                        end else
                            col_q <= col_q + 14'h0001;
                    end
                end
                BHB_DONE: begin
                    if (!ctl_q[BHB_CTL_ENABLE])
                        state_q <= BHB_IDLE;
                end
                default: state_q <= BHB_IDLE;
            endcase
        end
    end

    // ==========================================
    // colour, gain, shift, bin and region
    // the gained value is not clipped before the shift; the top bin takes
    // everything above the bin range
    logic [1:0] colour;
    logic [7:0] gain;
    logic [21:0] scaled;
    logic [21:0] shifted;
    logic [7:0] bin_max, bin;
    logic [3:0] hit;
    logic [1:0] region;
    logic any_hit;
    logic [BHB_AW-1:0] bin_addr;

    assign colour = {line_q[0], col_q[0]};
    assign gain = gain_q[8 * colour +: 8];
    assign scaled = 22'(({8'h00, px_raw} * {14'h0000, gain})
                        >> BHB_GAIN_FRAC);
    assign shifted = scaled >> shift_amt;
    assign bin_max = 8'(9'(32 << bins_sel) - 9'h001);
    assign bin = (shifted > {14'h0000, bin_max}) ? bin_max
                                                 : shifted[7:0];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_region
            wire [13:0] c0 = cols_q[g][13:0];
            wire [13:0] c1 = cols_q[g][29:16];
            wire [13:0] r0 = rows_q[g][13:0];
            wire [13:0] r1 = rows_q[g][29:16];
            assign hit[g] = reg_en[g] && c0 != c1 && r0 != r1 &&
                            col_q >= c0 && col_q <= c1 &&
                            line_q >= r0 && line_q <= r1;
        end
    endgenerate

    always_comb begin
        any_hit = |hit;
        region = 2'd0;
        if (hit[0]) region = 2'd0;
        else if (hit[1]) region = 2'd1;
        else if (hit[2]) region = 2'd2;
        else if (hit[3]) region = 2'd3;
    end

    // each region holds four colour areas of one bin count each; regions
    // beyond what the bin count allows wrap, software keeps within them
    logic [BHB_AW-1:0] region_base, colour_off;
    always_comb begin
        region_base = '0;
        colour_off = '0;
        case (bins_sel)
            2'd0: begin
                region_base = {1'h0, region, 7'h00};
                colour_off = {3'h0, colour, 5'h00};
            end
            2'd1: begin
                region_base = {region, 8'h00};
                colour_off = {2'h0, colour, 6'h00};
            end
            2'd2: begin
                region_base = {region[0], 9'h000};
                colour_off = {1'h0, colour, 7'h00};
            end
            2'd3: begin
                region_base = '0;
                colour_off = {colour, 8'h00};
            end
            default: begin
                region_base = '0;
                colour_off = '0;
            end
        endcase
    end
    assign bin_addr = region_base + colour_off + {2'h0, bin};

    // ==========================================
    // counter memory update and software access
    // a port access in the same cycle as a counted pixel takes precedence
    // and that pixel is lost; software reads counters between frames
    wire sw_port = access && is_port;
    wire do_inc = px_valid && any_hit && !sw_port;
    // counters stick at all ones rather than wrap to a small value
    logic [BHB_CNT_WIDTH-1:0] cnt_now, cnt_next;
    assign cnt_now = mem[bin_addr];
    assign cnt_next = (cnt_now == BHB_CNT_MAX) ? cnt_now
                                               : cnt_now + 20'h00001;
    always_ff @(posedge clk) begin
        if (do_inc)
            mem[bin_addr] <= cnt_next;
        else if (sw_port && pwrite)
            mem[ptr_q] <= pwdata[BHB_CNT_WIDTH-1:0];
        else if (sw_port && ctl_q[BHB_CTL_CLEAR])
            mem[ptr_q] <= '0;
    end

    always_ff @(posedge clk) begin
        if (reset)
            ptr_q <= '0;
        else if (wr && paddr == BHB_OFF_PTR)
            ptr_q <= pwdata[BHB_AW-1:0];
        else if (sw_port)
            ptr_q <= ptr_q + 10'h001;
    end
endmodule // bhb_engine

// >>> rtl/bhb_pkg.sv
// constants and register map for the bayer histogram binning engine
package bhb_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] BHB_OFF_CONTROL = 8'h00;  // binning_control
    localparam logic [7:0] BHB_OFF_FRAME = 8'h04;    // frame_size
    localparam logic [7:0] BHB_OFF_GAIN = 8'h08;     // channel_gain_set
    localparam logic [7:0] BHB_OFF_PTR = 8'h0c;      // counter_memory_pointer
    localparam logic [7:0] BHB_OFF_PORT = 8'h10;     // counter_memory_port
    localparam logic [7:0] BHB_OFF_STATUS = 8'h14;
    localparam logic [7:0] BHB_OFF_RDSTART = 8'h18;  // memory_read_start
    localparam logic [7:0] BHB_OFF_STRIDE = 8'h1c;   // memory_line_stride
    localparam logic [7:0] BHB_OFF_COLS0 = 8'h20;    // region_columns n at +8n
    localparam logic [7:0] BHB_OFF_ROWS0 = 8'h24;    // region_rows n at +8n
    // ==========================================
    // binning_control fields
    localparam int BHB_CTL_ENABLE = 0;
    localparam int BHB_CTL_SOURCE = 1;     // 0 video port, 1 memory
    localparam int BHB_CTL_PACKED = 2;     // packed_byte_pixels
    localparam int BHB_CTL_CLEAR = 3;      // clear_on_read
    localparam int BHB_CTL_BINS_LO = 4;    // 2 bits: 0=32 1=64 2=128 3=256
    localparam int BHB_CTL_PATTERN_LO = 6; // 2 bits, 0 = bayer
    localparam int BHB_CTL_SHIFT_LO = 8;   // 4 bits amplitude_downshift
    localparam int BHB_CTL_REGEN_LO = 12;  // 4 region enables
    localparam int BHB_CTL_WIDTH_LO = 16;  // 4 bits, memory pixel width
    localparam logic [31:0] BHB_CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] BHB_GAIN_RESET = 32'h2020_2020;  // unity gains
    // ==========================================
    // datapath sizes
    localparam int BHB_VP_WIDTH = 10;
    localparam int BHB_MEM_MIN_WIDTH = 8;
    localparam int BHB_MEM_MAX_WIDTH = 14;
    localparam int BHB_GAIN_FRAC = 5;
    localparam int BHB_CNT_WIDTH = 20;
    localparam int BHB_MEM_WORDS = 1024;
    localparam int BHB_AW = 10;
    localparam int BHB_COORD_W = 14;
    localparam logic [19:0] BHB_CNT_MAX = 20'hfffff;
    typedef enum logic [1:0] {
        BHB_IDLE = 2'b00,
        BHB_RUN = 2'b01,
        BHB_DONE = 2'b10
    } bhb_state_e;
endpackage

// >>> testbench/bayer_histogram_binning_bench.sv
// testbench of the bayer histogram binning engine
`timescale 1ns/100ps
module bayer_histogram_binning_bench
    import bhb_pkg::*;
;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic slow = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_start, rd_stride, rdat;
    logic pready, pslverr, vp_valid, rb_valid, rb_ready, frame_busy, err;
    logic [9:0] vp_data;
    logic [15:0] rb_data;
    int fail_count = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    bhb_engine u_bhb_engine (.clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .vp_valid, .vp_data, .rb_valid,
        .rb_data, .rb_ready, .rd_start, .rd_stride, .frame_busy);
    bhb_src_model u_bhb_src_model (.clk, .reset, .slow, .rb_ready, .vp_valid,
        .vp_data, .rb_valid, .rb_data);
    // ========
    // bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic cnt(input logic [9:0] a, input logic [31:0] e);
        apb(1'h1, BHB_OFF_PTR, {22'h0, a});
        rd_chk(BHB_OFF_PORT, e);
    endtask
    task automatic frame_end;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 100 && frame_busy !== 1'h0; i++) @(posedge clk);
        rd_chk(BHB_OFF_STATUS, 32'h2);
    endtask
    task automatic end_sim;
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        rd_chk(BHB_OFF_GAIN, BHB_GAIN_RESET);
        rd_chk(BHB_OFF_CONTROL, BHB_CTL_RESET);
        apb(1'h1, BHB_OFF_RDSTART, 32'h1234_5677);
        apb(1'h1, BHB_OFF_STRIDE, 32'h0000_0abc);
        @(negedge clk);
        chk(rd_start, 32'h1234_5660);
        chk(rd_stride, 32'h0000_0aa0);
        rd_chk(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'h1, BHB_OFF_PTR, 32'h0);
        for (int i = 0; i < BHB_MEM_WORDS; i++) apb(1'h1, BHB_OFF_PORT, 32'h0);
        // ========
        // video port, 256 bins, shift 2, gains 1, 2, 0.5, 1
        apb(1'h1, BHB_OFF_PTR, 32'h64);
        apb(1'h1, BHB_OFF_PORT, 32'h000f_fffe);
        apb(1'h1, BHB_OFF_FRAME, 32'h0002_0004);
        apb(1'h1, BHB_OFF_GAIN, 32'h2010_4020);
        apb(1'h1, BHB_OFF_COLS0, 32'h0003_0000);
        apb(1'h1, BHB_OFF_ROWS0, 32'h0001_0000);
        apb(1'h1, BHB_OFF_CONTROL, 32'h0000_1231);
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            u_bhb_src_model.vq.push_back(i == 1 ? 10'h3ff : 10'h190);
        frame_end();
        cnt(10'h064, 32'h000f_ffff);
        cnt(10'h1ff, 32'h1);
        cnt(10'h1c7, 32'h0);
        rd_chk(BHB_OFF_PORT, 32'h1);
        cnt(10'h232, 32'h2);
        cnt(10'h364, 32'h2);
        // ========
        // packed memory words, 32 bins, shift 3, three regions, slow source
        apb(1'h1, BHB_OFF_CONTROL, 32'h0);
        slow <= 1'h1;
        apb(1'h1, BHB_OFF_FRAME, 32'h0003_0002);
        apb(1'h1, BHB_OFF_GAIN, BHB_GAIN_RESET);
        for (int r = 0; r < 3; r++) begin
            apb(1'h1, BHB_OFF_COLS0 + 8'(8 * r), r == 2 ? 32'h0001_0001 : 32'h0001_0000);
            apb(1'h1, BHB_OFF_ROWS0 + 8'(8 * r), r == 0 ? 32'h0001_0000 : 32'h0002_0000);
        end
        apb(1'h1, BHB_OFF_CONTROL, 32'h0008_730f);
        u_bhb_src_model.rq = '{16'h2850, 16'hff10, 16'h3020};
        frame_end();
        cnt(10'h00a, 32'h1);
        cnt(10'h025, 32'h1);
        cnt(10'h042, 32'h1);
        cnt(10'h07f, 32'h1);
        cnt(10'h084, 32'h1);
        cnt(10'h0a6, 32'h1);
        cnt(10'h08a, 32'h0);
        cnt(10'h125, 32'h0);
        cnt(10'h17f, 32'h0);
        cnt(10'h00a, 32'h0);
        // ========
        // unpacked 10-bit memory words, 64 bins, shift 4, region 3 only
        apb(1'h1, BHB_OFF_CONTROL, 32'h0);
        slow <= 1'h0;
        apb(1'h1, BHB_OFF_FRAME, 32'h0001_0002);
        apb(1'h1, BHB_OFF_COLS0 + 8'h18, 32'h0001_0000);
        apb(1'h1, BHB_OFF_ROWS0 + 8'h18, 32'h0001_0000);
        apb(1'h1, BHB_OFF_CONTROL, 32'h000a_8413);
        u_bhb_src_model.rq = '{16'hfc40, 16'h0155};
        frame_end();
        cnt(10'h304, 32'h1);
        cnt(10'h355, 32'h1);
        cnt(10'h33f, 32'h0);
        end_sim();
    end
endmodule // bayer_histogram_binning_bench

// >>> testbench/bhb_engine_chk.sv
// port checker of the binning engine
`timescale 1ns/100ps
module bhb_engine_chk
    import bhb_pkg::*;
(
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic vp_valid, // pixel valid
    input wire logic rb_valid, // word valid
    input wire logic rb_ready, // word taken
    input wire logic [31:0] rd_start, // read start
    input wire logic [31:0] rd_stride, // line stride
    input wire logic frame_busy // binning on
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire acc = psel && penable;
    wire ctl_wr = acc && pwrite && paddr == BHB_OFF_CONTROL;
    wire st_wr = acc && pwrite && paddr == BHB_OFF_RDSTART;
    wire go = ctl_wr && pwdata[0];
    // ========
    // register bus and frame flow
    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_bad; acc && paddr >= 8'h40 |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_bad: assert property (p_bad) else $error("unmapped kept");
    property p_map; acc && paddr < 8'h40 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_map: assert property (p_map) else $error("mapped refused");
    property p_align; rd_start[4:0] == 5'h0 && rd_stride[4:0] == 5'h0; endproperty
    a_align: assert property (p_align) else $error("unaligned");
    property p_start; $changed(rd_start) |-> $past(st_wr) || $past(reset); endproperty
    a_start: assert property (p_start) else $error("start moved");
    property p_rb; rb_ready |-> rb_valid && frame_busy; endproperty
    a_rb: assert property (p_rb) else $error("word taken idle");
    property p_rise; $rose(frame_busy) |-> $past(go, 2); endproperty
    a_rise: assert property (p_rise) else $error("frame began");
    property p_fall;
        $fell(frame_busy) |-> $past(vp_valid || rb_valid) ||
            $past(ctl_wr, 2) || $past(reset);
    endproperty
    a_fall: assert property (p_fall) else $error("frame ended");
    c_run: cover property ($rose(frame_busy));
    c_done: cover property ($fell(frame_busy));
    c_err: cover property (pslverr);
    c_word: cover property (rb_ready);
endmodule // bhb_engine_chk
bind bhb_engine bhb_engine_chk u_bhb_engine_chk (.clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vp_valid, .rb_valid, .rb_ready, .rd_start, .rd_stride, .frame_busy);

// >>> testbench/bhb_src_model.sv
// pixel source: video port stream and memory read buffer words
`timescale 1ns/100ps
module bhb_src_model (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic slow, // idle a cycle after each transfer
    input wire logic rb_ready, // word taken
    output logic vp_valid = 1'h0, // pixel valid
    output logic [9:0] vp_data = 10'h0, // pixel
    output logic rb_valid = 1'h0, // word valid
    output logic [15:0] rb_data = 16'h0 // memory word
);
    logic [9:0] vq[$];
    logic [15:0] rq[$];
    always @(posedge clk) begin
        if (rb_valid && rb_ready) begin
            void'(rq.pop_front());
        end
        if (!reset && rq.size() > 0 && !(slow && rb_valid && rb_ready)) begin
            rb_valid <= 1'h1;
            rb_data <= rq[0];
        end else begin
            rb_valid <= 1'h0;
            rb_data <= ~rb_data;
        end
        if (!reset && vq.size() > 0 && !(slow && vp_valid)) begin
            vp_valid <= 1'h1;
            vp_data <= vq.pop_front();
        end else begin
            vp_valid <= 1'h0;
            vp_data <= ~vp_data;
        end
    end
endmodule // bhb_src_model
